// [axs_cmp.sv]
// one position comparator channel
`timescale 1ns/10ps
`default_nettype none
`include "axs_map.svh"
module axs_cmp
    import axs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    axs_cmp_if.chan cif
);
    logic eq_w;
    logic was_eq_q;
    logic match_q;

    // equality on the selected position
    assign eq_w = (cif.position == cif.target);
    assign cif.match = match_q;

    // pulse on arrival only, so a parked axis gives one trigger not a stream
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            was_eq_q <= `AXS_RST_VAL;
            match_q <= `AXS_RST_VAL;
        end
        else
        begin
            was_eq_q <= eq_w;
            match_q <= cif.enable & eq_w & ~was_eq_q;
        end
    end

    AST_CMP_CAUSE: assert property (@(posedge mclk) disable iff (!rst_n)
        match_q |-> $past(eq_w && cif.enable && !was_eq_q))
        else $error("compare pulse without a new match");
    AST_CMP_SINGLE: assert property (@(posedge mclk) disable iff (!rst_n)
        match_q |=> !match_q)
        else $error("compare pulse longer than one cycle");
endmodule
`default_nettype wire

// [axs_cmp_if.sv]
// carrier between supervisor core and one position comparator
`timescale 1ns/10ps
`default_nettype none
interface axs_cmp_if;
    import axs_pkg::*;
    logic enable;
    axs_pos_t target;
    axs_pos_t position;
    logic match;
    modport chan (input enable, input target, input position, output match);
    modport core (output enable, output target, output position, input match);
endinterface
`default_nettype wire

// [axs_drive_model.sv]
// behavioural servo drive model for the axis supervisor bench
`timescale 1ns/10ps
`default_nettype none
module axs_drive_model #(
    parameter int RDY_DLY = 5
)(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [3:0] drive_enable_out,
    input wire logic [3:0] drive_fault_reset_out,
    input wire logic [3:0] axis_busy_in,
    input wire logic [3:0] fault_inject,
    output logic [3:0] drive_fault_in,
    output logic [3:0] drive_ready_in,
    output logic [3:0] drive_in_position_in
);
    logic [3:0] fault_q;
    int cnt [4];
    // fault holds until the clearing pulse is seen
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            fault_q <= 4'h0;
        else
            fault_q <= (fault_q | fault_inject) & ~drive_fault_reset_out;
    end
    // slow drive: ready only after servo-on has stood a while
    always @(posedge mclk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (drive_enable_out[i] && !fault_q[i])
                cnt[i] <= (cnt[i] < RDY_DLY) ? cnt[i] + 1 : cnt[i];
            else
                cnt[i] <= 0;
        end
    end
    // status lines seen by the supervisor
    always_comb
    begin
        drive_fault_in = fault_q;
        for (int i = 0; i < 4; i++)
        begin
            drive_ready_in[i] = cnt[i] >= RDY_DLY;
            drive_in_position_in[i] = drive_ready_in[i] && !axis_busy_in[i];
        end
    end
endmodule
`default_nettype wire

// [axs_map.svh]
// constants of the axis supervisor: sizes and timing figures
`ifndef AXS_MAP_SVH
`define AXS_MAP_SVH
`define AXS_NAXIS 4
`define AXS_NCMP 2
`define AXS_POS_W 32
`define AXS_SRC_W 2
`define AXS_CNT_W 16
`define AXS_NSENSE 8
`define AXS_CLK_NS 25
`define AXS_ERC_NS 10000
`define AXS_FCLR_NS 10000
`define AXS_TRIG_NS 1000
`define AXS_RST_VAL 1'b0
`endif

// [axs_pkg.sv]
// types shared by the axis supervisor files
`include "axs_map.svh"
package axs_pkg;
    typedef logic [`AXS_SRC_W-1:0] axs_src_t;
    typedef logic [`AXS_POS_W-1:0] axs_pos_t;
    typedef logic [`AXS_CNT_W-1:0] axs_cnt_t;
endpackage

// [axs_supervisor.sv]
// four-axis sensor, servo drive and position compare supervision
// What this block does
// - emergency stop active halts pulse generation on all axes, protected state.
// - no axis may run until emergency stop is inactive again.
// - active end limit stops that axis's motion toward the limit.
// - end limit trigger pulses that axis's error-counter-clear output.
// - hardware emergency stop trigger pulses all error-counter-clear outputs.
// - software emergency stop command pulses all error-counter-clear outputs too.
// - software force command holds an axis's error-counter-clear output active.
// - passing the slow-down sensor switches the axis to deceleration speed.
// - slow-down sensor acts only when software enabled slow-down for the axis.
// - compare output pulses when selected axis position equals programmed value.
// - two independent position comparators, channel 0 and channel 1.
// - one servo-on output per axis enabling or disabling the drive.
// - one alarm-clear output per axis resets the drive's alarm.
// - each of four axes has one software-driven general output.
`timescale 1ns/10ps
`default_nettype none
`include "axs_map.svh"
module axs_supervisor
    import axs_pkg::*;
#(
    parameter int NAXIS = `AXS_NAXIS,
    parameter int NCMP = `AXS_NCMP,
    parameter int ERC_NS = `AXS_ERC_NS,
    parameter int FCLR_NS = `AXS_FCLR_NS,
    parameter int TRIG_NS = `AXS_TRIG_NS
)(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic estop_in,
    input wire logic [NAXIS-1:0] plus_end_limit_in,
    input wire logic [NAXIS-1:0] minus_end_limit_in,
    input wire logic [NAXIS-1:0] home_sensor_in,
    input wire logic [NAXIS-1:0] slowdown_sensor_in,
    input wire logic [NAXIS-1:0] drive_fault_in,
    input wire logic [NAXIS-1:0] drive_ready_in,
    input wire logic [NAXIS-1:0] drive_in_position_in,
    input wire logic [NAXIS-1:0] axis_gp_in,
    input wire logic sw_estop_cmd,
    input wire logic sw_estop_release,
    input wire logic [NAXIS-1:0] erc_force_on,
    input wire logic [NAXIS-1:0] slowdown_enable,
    input wire logic [NAXIS-1:0] drive_enable_cmd,
    input wire logic [NAXIS-1:0] fault_reset_cmd,
    input wire logic [NAXIS-1:0] gp_out_cmd,
    input wire logic [NAXIS-1:0] axis_dir_in,
    input wire logic [NAXIS-1:0] axis_busy_in,
    input wire logic [NAXIS-1:0][`AXS_POS_W-1:0] axis_position,
    input wire logic [NCMP-1:0] cmp_enable,
    input wire logic [NCMP-1:0][`AXS_SRC_W-1:0] cmp_src,
    input wire logic [NCMP-1:0][`AXS_POS_W-1:0] cmp_target,
    output logic [NAXIS-1:0] axis_run_permit,
    output logic [NAXIS-1:0] axis_slow_sel,
    output logic [NAXIS-1:0] drive_enable_out,
    output logic [NAXIS-1:0] drive_fault_reset_out,
    output logic [NAXIS-1:0] drive_err_clear_out,
    output logic [NAXIS-1:0] axis_gp_out,
    output logic [NCMP-1:0] position_match_pulse,
    output logic match_trigger_out,
    output logic sw_estop_sts,
    output logic estop_sts,
    output logic [NAXIS-1:0] plus_limit_sts,
    output logic [NAXIS-1:0] minus_limit_sts,
    output logic [NAXIS-1:0] home_sts,
    output logic [NAXIS-1:0] slowdown_sts,
    output logic [NAXIS-1:0] drive_fault_sts,
    output logic [NAXIS-1:0] drive_ready_sts,
    output logic [NAXIS-1:0] drive_in_position_sts,
    output logic [NAXIS-1:0] axis_gp_in_sts
);
    localparam int SW = `AXS_NSENSE * NAXIS + 1;
    // least times, rounded up to whole cycles
    localparam int ERC_CYC = (ERC_NS + `AXS_CLK_NS - 1) / `AXS_CLK_NS;
    localparam int FCLR_CYC = (FCLR_NS + `AXS_CLK_NS - 1) / `AXS_CLK_NS;
    localparam int TRIG_CYC = (TRIG_NS + `AXS_CLK_NS - 1) / `AXS_CLK_NS;
    localparam axs_cnt_t ERC_LD = `AXS_CNT_W'(ERC_CYC);
    localparam axs_cnt_t FCLR_LD = `AXS_CNT_W'(FCLR_CYC);
    localparam axs_cnt_t TRIG_LD = `AXS_CNT_W'(TRIG_CYC);

    // slice k of a packed sensor vector
    function automatic logic [NAXIS-1:0] fld(input logic [SW-1:0] v, input int k);
        return v[k*NAXIS +: NAXIS];
    endfunction

    // pulse stretcher step: reload on trigger, else count down to zero
    function automatic axs_cnt_t stretch(input logic trig, input axs_cnt_t cnt,
                                         input axs_cnt_t ld);
        if (trig)
            return ld;
        else if (cnt != '0)
            return cnt - `AXS_CNT_W'(1);
        else
            return '0;
    endfunction

    logic rst_m_q;
    logic rst_n;
    logic [SW-1:0] raw_w;
    logic [SW-1:0] meta_q;
    logic [SW-1:0] sync_q;
    logic [SW-1:0] prev_q;
    logic estop_s;
    logic estop_rise;
    logic [NAXIS-1:0] lim_p_s;
    logic [NAXIS-1:0] lim_m_s;
    logic [NAXIS-1:0] lim_rise;
    logic [NAXIS-1:0] slow_s;
    logic [NAXIS-1:0] slow_rise;
    logic [NAXIS-1:0] fault_s;
    logic [NAXIS-1:0] dir_block;
    logic [NAXIS-1:0] erc_trig;
    logic halt_all;
    logic sw_estop_q;
    logic sw_estop_d;
    logic [NAXIS-1:0] permit_q;
    logic [NAXIS-1:0] permit_d;
    logic [NAXIS-1:0] slow_q;
    logic [NAXIS-1:0] slow_d;
    logic [NAXIS-1:0] servo_on_q;
    logic [NAXIS-1:0] erc_q;
    logic [NAXIS-1:0] fclr_q;
    logic [NAXIS-1:0] gpo_q;
    logic [NCMP-1:0] match_w;
    logic trig_q;
    axs_cnt_t trig_cnt_q;
    axs_cnt_t trig_cnt_d;

    // reset release through two flops; assertion is still immediate
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_m_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_m_q <= 1'b1;
            rst_n <= rst_m_q;
        end
    end

    // all field inputs gathered for one synchroniser bank
    assign raw_w = {estop_in, plus_end_limit_in, minus_end_limit_in, home_sensor_in,
                    slowdown_sensor_in, drive_fault_in, drive_ready_in,
                    drive_in_position_in, axis_gp_in};

    // meta_q feeds only sync_q; edges are taken between sync_q and prev_q
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end
        else
        begin
            meta_q <= raw_w;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // decoded sensor levels and edges
    assign estop_s = sync_q[SW-1];
    assign estop_rise = sync_q[SW-1] & ~prev_q[SW-1];
    assign lim_p_s = fld(sync_q, 7);
    assign lim_m_s = fld(sync_q, 6);
    assign slow_s = fld(sync_q, 4);
    assign fault_s = fld(sync_q, 3);
    assign lim_rise = (lim_p_s & ~fld(prev_q, 7)) | (lim_m_s & ~fld(prev_q, 6));
    assign slow_rise = slow_s & ~fld(prev_q, 4);

    // status outputs are the synchroniser's second stage
    assign estop_sts = estop_s;
    assign plus_limit_sts = lim_p_s;
    assign minus_limit_sts = lim_m_s;
    assign home_sts = fld(sync_q, 5);
    assign slowdown_sts = slow_s;
    assign drive_fault_sts = fault_s;
    assign drive_ready_sts = fld(sync_q, 2);
    assign drive_in_position_sts = fld(sync_q, 1);
    assign axis_gp_in_sts = fld(sync_q, 0);

    // software stop latch; a command in the release cycle wins
    assign sw_estop_d = sw_estop_cmd | (sw_estop_q & ~sw_estop_release);
    assign halt_all = estop_s | sw_estop_q;

    // motion permit: only the direction into a limit is blocked, so backing out works
    assign dir_block = (axis_dir_in & lim_p_s) | (~axis_dir_in & lim_m_s);
    assign permit_d = ~{NAXIS{halt_all}} & ~dir_block & ~fault_s;

    // slow-down latch held while the axis stays busy and the function enabled
    assign slow_d = slowdown_enable & axis_busy_in & (slow_q | slow_rise);

    // error clear triggers: own limit edge, hardware stop edge, software stop
    assign erc_trig = lim_rise | {NAXIS{estop_rise | sw_estop_cmd}};

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sw_estop_q <= 1'b0;
            permit_q <= '0;
            slow_q <= '0;
            servo_on_q <= '0;
            gpo_q <= '0;
        end
        else
        begin
            sw_estop_q <= sw_estop_d;
            permit_q <= permit_d;
            slow_q <= slow_d;
            servo_on_q <= drive_enable_cmd & ~{NAXIS{halt_all}};
            gpo_q <= gp_out_cmd;
        end
    end

    // per-axis stretched pulses toward the drive
    for (genvar i = 0; i < NAXIS; i++)
    begin : g_axis
        axs_cnt_t erc_cnt_q;
        axs_cnt_t erc_cnt_d;
        axs_cnt_t fclr_cnt_q;
        axs_cnt_t fclr_cnt_d;
        assign erc_cnt_d = stretch(erc_trig[i], erc_cnt_q, ERC_LD);
        assign fclr_cnt_d = stretch(fault_reset_cmd[i], fclr_cnt_q, FCLR_LD);
        always_ff @(posedge mclk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                erc_cnt_q <= '0;
                fclr_cnt_q <= '0;
                erc_q[i] <= 1'b0;
                fclr_q[i] <= 1'b0;
            end
            else
            begin
                erc_cnt_q <= erc_cnt_d;
                fclr_cnt_q <= fclr_cnt_d;
                erc_q[i] <= erc_force_on[i] | (erc_cnt_d != '0);
                fclr_q[i] <= fclr_cnt_d != '0;
            end
        end
    end

    // two comparator channels, each with its own source axis
    for (genvar c = 0; c < NCMP; c++)
    begin : g_cmp
        axs_cmp_if cif ();
        assign cif.enable = cmp_enable[c];
        assign cif.target = cmp_target[c];
        assign cif.position = axis_position[cmp_src[c]];
        assign match_w[c] = cif.match;
        axs_cmp u_cmp (
            .mclk (mclk),
            .rst_n (rst_n),
            .cif (cif)
        );
    end

    // shared trigger pin stretched so slow cameras see it
    assign trig_cnt_d = stretch(|match_w, trig_cnt_q, TRIG_LD);
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trig_cnt_q <= '0;
            trig_q <= 1'b0;
        end
        else
        begin
            trig_cnt_q <= trig_cnt_d;
            trig_q <= trig_cnt_d != '0;
        end
    end

    assign axis_run_permit = permit_q;
    assign axis_slow_sel = slow_q;
    assign drive_enable_out = servo_on_q;
    assign drive_fault_reset_out = fclr_q;
    assign drive_err_clear_out = erc_q;
    assign axis_gp_out = gpo_q;
    assign position_match_pulse = match_w;
    assign match_trigger_out = trig_q;
    assign sw_estop_sts = sw_estop_q;

    AST_ESTOP_HALT: assert property (@(posedge mclk) disable iff (!rst_n)
        estop_s |=> (permit_q == '0) && (servo_on_q == '0))
        else $error("axes not halted under emergency stop");
    AST_ESTOP_REFUSE: assert property (@(posedge mclk) disable iff (!rst_n)
        (permit_q != '0) |-> $past(!estop_s && !sw_estop_q))
        else $error("motion permitted during emergency stop");
    AST_LIMIT_STOP: assert property (@(posedge mclk) disable iff (!rst_n)
        (lim_p_s[0] && axis_dir_in[0]) |=> !permit_q[0])
        else $error("axis 0 permitted into plus limit");
    AST_ERC_LIMIT: assert property (@(posedge mclk) disable iff (!rst_n)
        lim_rise[1] |=> erc_q[1] [*8])
        else $error("limit edge gave no error clear pulse");
    AST_ERC_ESTOP: assert property (@(posedge mclk) disable iff (!rst_n)
        estop_rise |=> (erc_q == '1) [*4])
        else $error("hardware stop gave no error clear");
    AST_ERC_SW: assert property (@(posedge mclk) disable iff (!rst_n)
        sw_estop_cmd |=> (erc_q == '1) && sw_estop_q)
        else $error("software stop gave no error clear");
    AST_ERC_FORCE: assert property (@(posedge mclk) disable iff (!rst_n)
        erc_force_on[2] |=> erc_q[2])
        else $error("forced error clear not driven");
    AST_SLOW_GATE: assert property (@(posedge mclk) disable iff (!rst_n)
        slow_q[0] |-> $past(slowdown_enable[0]))
        else $error("slow-down acted while disabled");
    AST_SLOW_SET: assert property (@(posedge mclk) disable iff (!rst_n)
        (slowdown_enable[3] && axis_busy_in[3] && slow_rise[3]) |=> slow_q[3])
        else $error("slow-down sensor ignored");
    AST_FAULT_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
        fault_reset_cmd[3] |=> fclr_q[3] [*8])
        else $error("alarm clear pulse missing");
    AST_TRIG: assert property (@(posedge mclk) disable iff (!rst_n)
        (|match_w) |=> trig_q [*8])
        else $error("compare trigger pin not pulsed");
    AST_SERVO_ON: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(servo_on_q[1]) |-> $past(drive_enable_cmd[1] && !halt_all))
        else $error("servo-on without command");
endmodule
`default_nettype wire

// [axs_supervisor_tail.sv]
// spare source of the axis supervisor; holds no logic
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [testbench.sv]
// self-checking bench for the axis supervisor
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic estop_in = 1'b0, sw_estop_cmd = 1'b0, sw_estop_release = 1'b0;
    logic [3:0] plus_end_limit_in = 4'h0, minus_end_limit_in = 4'h0, home_sensor_in = 4'h0;
    logic [3:0] slowdown_sensor_in = 4'h0, axis_gp_in = 4'h0, erc_force_on = 4'h0;
    logic [3:0] slowdown_enable = 4'h0, drive_enable_cmd = 4'h0, fault_reset_cmd = 4'h0;
    logic [3:0] gp_out_cmd = 4'h0, axis_dir_in = 4'h0, axis_busy_in = 4'h0, fault_inject = 4'h0;
    logic [3:0][31:0] axis_position = '0;
    logic [1:0] cmp_enable = 2'h0;
    logic [1:0][1:0] cmp_src = '0;
    logic [1:0][31:0] cmp_target = '0;
    logic [3:0] drive_fault_in, drive_ready_in, drive_in_position_in;
    logic [3:0] axis_run_permit, axis_slow_sel, drive_enable_out, drive_fault_reset_out;
    logic [3:0] drive_err_clear_out, axis_gp_out, plus_limit_sts, minus_limit_sts, home_sts;
    logic [3:0] slowdown_sts, drive_fault_sts, drive_ready_sts, drive_in_position_sts;
    logic [3:0] axis_gp_in_sts;
    logic [1:0] position_match_pulse;
    logic match_trigger_out, sw_estop_sts, estop_sts;
    int fails = 0, comparisons = 0;
    // row: estop plim mlim dir busy slen sens drv, spare, permit slow enable
    localparam logic [11:0] rows [8] = '{12'h015, 12'h810, 12'h580, 12'h484,
        12'h280, 12'h384, 12'h0E6, 12'h0A4};

    axs_supervisor dut (.mclk, .arst_n, .estop_in, .plus_end_limit_in, .minus_end_limit_in,
        .home_sensor_in, .slowdown_sensor_in, .drive_fault_in, .drive_ready_in,
        .drive_in_position_in, .axis_gp_in, .sw_estop_cmd, .sw_estop_release, .erc_force_on,
        .slowdown_enable, .drive_enable_cmd, .fault_reset_cmd, .gp_out_cmd, .axis_dir_in,
        .axis_busy_in, .axis_position, .cmp_enable, .cmp_src, .cmp_target, .axis_run_permit,
        .axis_slow_sel, .drive_enable_out, .drive_fault_reset_out, .drive_err_clear_out,
        .axis_gp_out, .position_match_pulse, .match_trigger_out, .sw_estop_sts, .estop_sts,
        .plus_limit_sts, .minus_limit_sts, .home_sts, .slowdown_sts, .drive_fault_sts,
        .drive_ready_sts, .drive_in_position_sts, .axis_gp_in_sts);
    axs_drive_model drive (.mclk, .arst_n, .drive_enable_out, .drive_fault_reset_out,
        .axis_busy_in, .fault_inject, .drive_fault_in, .drive_ready_in, .drive_in_position_in);

    always #12.5 mclk = ~mclk;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic finish_test();
        if (fails == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    function automatic logic pick(input int sel, input logic [3:0] mask);
        case (sel)
            0: pick = drive_err_clear_out === mask;
            1: pick = drive_fault_reset_out === mask;
            2: pick = position_match_pulse === mask[1:0];
            default: pick = match_trigger_out === 1'b1;
        endcase
    endfunction
    // bounded wait for the pulse, then count the edges it stays up
    task automatic width(input int sel, input logic [3:0] mask, input int exp);
        int n;
        int w;
        n = 0;
        w = 0;
        while (!pick(sel, mask) && n < 60)
        begin
            @(posedge mclk);
            n++;
        end
        while (pick(sel, mask) && w < 1000)
        begin
            @(posedge mclk);
            w++;
        end
        chk("pulse width", exp, w);
        if (n >= 60)
            finish_test();
    endtask
    // same level on every axis, so all four lanes are exercised
    task automatic apply(input logic [7:0] r);
        @(posedge mclk);
        estop_in <= r[7];
        plus_end_limit_in <= {4{r[6]}};
        minus_end_limit_in <= {4{r[5]}};
        axis_dir_in <= {4{r[4]}};
        axis_busy_in <= {4{r[3]}};
        slowdown_enable <= {4{r[2]}};
        slowdown_sensor_in <= {4{r[1]}};
        drive_enable_cmd <= {4{r[0]}};
    endtask

    initial
    begin
        cyc(8);
        chk("reset outputs", 32'h0, {axis_run_permit, axis_slow_sel, drive_enable_out,
            drive_err_clear_out, drive_fault_reset_out, match_trigger_out});
        arst_n <= 1'b1;
        cyc(4);
        for (int i = 0; i < 8; i++)
        begin
            apply(rows[i][11:4]);
            cyc(16);
            chk("run permit", {4{rows[i][2]}}, axis_run_permit);
            chk("slow select", {4{rows[i][1]}}, axis_slow_sel);
            chk("drive enable", {4{rows[i][0]}}, drive_enable_out);
            chk("slowdown status", {4{rows[i][5]}}, slowdown_sts);
            apply(8'h00);
            cyc(8);
        end
        // let clear pulses left by the rows run out
        cyc(420);
        plus_end_limit_in <= 4'h2;
        width(0, 4'h2, 400);
        chk("plus limit status", 32'h2, plus_limit_sts);
        plus_end_limit_in <= 4'h0;
        minus_end_limit_in <= 4'h1;
        width(0, 4'h1, 400);
        chk("minus limit status", 32'h1, minus_limit_sts);
        minus_end_limit_in <= 4'h0;
        estop_in <= 1'b1;
        width(0, 4'hF, 400);
        chk("estop status", 32'h1, estop_sts);
        chk("permit under estop", 32'h0, axis_run_permit);
        estop_in <= 1'b0;
        cyc(6);
        chk("permit after estop", 32'hF, axis_run_permit);
        // residual count cleared before servo-on
        erc_force_on <= 4'h4;
        cyc(500);
        chk("forced clear", 32'h4, drive_err_clear_out);
        drive_enable_cmd <= 4'h4;
        cyc(16);
        chk("drive enable", 32'h4, drive_enable_out);
        chk("ready status", 32'h4, drive_ready_sts);
        chk("in position status", 32'h4, drive_in_position_sts);
        erc_force_on <= 4'h0;
        cyc(6);
        chk("clear released", 32'h0, drive_err_clear_out);
        // set and release together: set must win
        sw_estop_cmd <= 1'b1;
        sw_estop_release <= 1'b1;
        @(posedge mclk);
        sw_estop_cmd <= 1'b0;
        sw_estop_release <= 1'b0;
        width(0, 4'hF, 400);
        chk("software stop latch", 32'h1, sw_estop_sts);
        chk("permit under software stop", 32'h0, axis_run_permit);
        chk("enable under software stop", 32'h0, drive_enable_out);
        sw_estop_release <= 1'b1;
        @(posedge mclk);
        sw_estop_release <= 1'b0;
        cyc(20);
        chk("software stop released", 32'h0F4, {sw_estop_sts, axis_run_permit,
            drive_enable_out});
        fault_inject <= 4'h8;
        @(posedge mclk);
        fault_inject <= 4'h0;
        cyc(8);
        chk("fault status", 32'h8, drive_fault_sts);
        chk("permit with fault", 32'h7, axis_run_permit);
        fault_reset_cmd <= 4'h8;
        @(posedge mclk);
        fault_reset_cmd <= 4'h0;
        width(1, 4'h8, 400);
        chk("fault cleared", 32'h0, drive_fault_sts);
        gp_out_cmd <= 4'hA;
        axis_gp_in <= 4'h5;
        home_sensor_in <= 4'h3;
        cyc(6);
        chk("general outputs", 32'hA, axis_gp_out);
        chk("general input status", 32'h5, axis_gp_in_sts);
        chk("home status", 32'h3, home_sts);
        cmp_enable <= 2'h3;
        cmp_src <= {2'h3, 2'h1};
        cmp_target <= {32'h0000_0200, 32'h0000_0100};
        cyc(4);
        axis_position[1] <= 32'h0000_0100;
        width(2, 4'h1, 1);
        width(3, 4'h0, 40);
        axis_position[3] <= 32'h0000_0200;
        width(2, 4'h2, 1);
        width(3, 4'h0, 40);
        cyc(50);
        chk("no repeat match", 32'h0, {match_trigger_out, position_match_pulse});
        finish_test();
    end
endmodule
`default_nettype wire
